// file: include/psb_params.svh
`ifndef PSB_PARAMS_SVH
`define PSB_PARAMS_SVH
// ----------------------------------------
// bus geometry
// ----------------------------------------
`define PSB_DATA_W 8
`define PSB_CA_BYTES 6
// ----------------------------------------
// latency and memory
// ----------------------------------------
`define PSB_LATENCY_CLKS 4
`define PSB_MEM_AW 8
// reset value of the latency indicator, extra latency requested
`define PSB_EXTRA_LAT_RST 1'b1
// ----------------------------------------
// select low limit, industrial grade
// ----------------------------------------
`define PSB_SEL_LIMIT_NS 4000
`define PSB_CLK_NS 8
`define PSB_SEL_LIMIT_CYC (`PSB_SEL_LIMIT_NS / `PSB_CLK_NS)
`endif

// file: include/psb_pkg.sv
package psb_pkg;
  // transaction phase
  typedef enum logic [2:0] {
    PSB_IDLE,
    PSB_CMD,
    PSB_LAT,
    PSB_RDATA,
    PSB_WDATA
  } psb_phase_t;

  // pin bundle toward the bus
  typedef struct packed {
    logic [7:0] dq_o;
    logic dq_oe;
    logic strobe_o;
    logic strobe_oe;
  } psb_pins_t;
endpackage

// file: verilog/psb_mem.sv
`timescale 1ns/100ps
`include "psb_params.svh"
// ----------------------------------------
// byte memory with registered read data
// ----------------------------------------
module psb_mem #(
  parameter int AW = `PSB_MEM_AW
) (
  input wire logic mclk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  // refuse address widths the array cannot hold
  if (AW < 1 || AW > 16) begin : g_bad_aw
    $error("psb_mem: unsupported address width");
  end

  logic [7:0] mem [0:(1<<AW)-1]; // storage array

  // write port and registered read
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// file: verilog/psb_dev.sv
`timescale 1ns/100ps
`include "psb_params.svh"
// Operation
// - select falling starts, rising ends transaction
// - capture and launch on bus clock edges
// - command and data share 8-bit bus
// - strobe shows extra latency at start
// - write strobe is host byte mask
// - read strobe timed by shifted clock
// - shifted clock single-ended only
// - reset idles and floats strobe and data
module psb_dev
  import psb_pkg::*;
#(
  parameter int AW = `PSB_MEM_AW,
  parameter int LAT = `PSB_LATENCY_CLKS,
  parameter int SEL_LIMIT = `PSB_SEL_LIMIT_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic select_n,
  input wire logic bus_clock,
  input wire logic shifted_clock,
  input wire logic centered_read_strobe_option,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o,
  output logic dq_oe,
  input wire logic read_write_strobe_i,
  output logic read_write_strobe_o,
  output logic read_write_strobe_oe,
  output logic select_overrun
);
  // latency counter is 5 bits and the select counter 13 bits wide
  if (AW < 1 || AW > 16 || LAT < 1 || LAT > 8 || SEL_LIMIT < 1 || SEL_LIMIT > 8191) begin : g_bad_param
    $error("psb_dev: unsupported parameters");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] cs_s;       // select synchroniser
    logic [1:0] ck_s;       // bus clock synchroniser
    logic [1:0] ps_s;       // shifted clock synchroniser
    logic [1:0] rw_s;       // strobe input synchroniser
    logic [15:0] dq_s;      // data input synchroniser
    logic ck_l;             // last synced bus clock
    logic ps_l;             // last synced shifted clock
    psb_phase_t ph;         // transaction phase
    logic [2:0] ca_n;       // command bytes taken
    logic rd;               // read transaction
    logic [AW-1:0] addr;    // byte address
    logic [4:0] lat_n;      // latency edges left
    logic extra;            // extra latency indicator
    logic [12:0] low_n;     // select low duration
    logic over;             // select held too long
    psb_pins_t pins;        // registered pin drives
  } psb_st_t;

  psb_st_t q, d;
  logic [7:0] mem_rd;
  logic mem_we;
  logic [AW-1:0] mem_addr;
  logic ck_edge, ps_edge, cs_lo, sel_start, sel_end;

  psb_mem #(.AW(AW)) u_mem (
    .mclk(mclk),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(q.dq_s[15:8]),
    .rdata(mem_rd)
  );

  // ----------------------------------------
  // edge detection on synchronised pins
  // ----------------------------------------
  always_comb begin
    ck_edge = q.ck_s[1] ^ q.ck_l;
    ps_edge = q.ps_s[1] ^ q.ps_l;
    cs_lo = ~q.cs_s[1];
    sel_start = cs_lo && q.ph == PSB_IDLE;
    sel_end = ~cs_lo && q.ph != PSB_IDLE;
    // write when the strobe mask is low on a data edge
    mem_we = q.ph == PSB_WDATA && ck_edge && cs_lo && ~q.rw_s[1];
    mem_addr = q.addr;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d = q;
    d.cs_s = {q.cs_s[0], select_n};
    d.ck_s = {q.ck_s[0], bus_clock};
    d.ps_s = {q.ps_s[0], shifted_clock};
    d.rw_s = {q.rw_s[0], read_write_strobe_i};
    d.dq_s = {q.dq_s[7:0], dq_i};
    d.ck_l = q.ck_s[1];
    d.ps_l = q.ps_s[1];
    case (q.ph)
      PSB_IDLE: begin
        if (sel_start) begin
          d.ph = PSB_CMD;
          d.ca_n = 3'h0;
          d.over = 1'b0;
          // drive latency indicator at start
          d.pins.strobe_oe = 1'b1;
          d.pins.strobe_o = q.extra;
        end
      end
      PSB_CMD: begin
        if (ck_edge) begin
          // command bytes arrive on the data bus
          case (q.ca_n)
            3'h0: d.rd = q.dq_s[15];
            3'h4: d.addr = AW'({q.addr, q.dq_s[15:8]});
            3'h5: d.addr = AW'({q.addr, q.dq_s[15:8]});
            default: d.addr = q.addr;
          endcase
          d.ca_n = q.ca_n + 3'h1;
          if (q.ca_n == 3'(`PSB_CA_BYTES - 1)) begin
            d.ph = PSB_LAT;
            d.lat_n = 5'((q.extra ? 4 : 2) * LAT - 1);
          end
        end
      end
      PSB_LAT: begin
        if (ck_edge) begin
          d.lat_n = q.lat_n - 5'h01;
          if (q.lat_n == 5'h00) begin
            d.extra = ~q.extra;
            d.ph = q.rd ? PSB_RDATA : PSB_WDATA;
            d.pins.strobe_oe = q.rd;
            d.pins.dq_oe = q.rd;
            d.pins.strobe_o = 1'b0;
          end
        end
      end
      PSB_RDATA: begin
        // one byte per bus clock edge
        if (ck_edge) begin
          d.pins.dq_o = mem_rd;
          d.addr = q.addr + AW'(1);
          if (!centered_read_strobe_option) begin
            d.pins.strobe_o = ~q.pins.strobe_o;
          end
        end
        if (centered_read_strobe_option && ps_edge) begin
          d.pins.strobe_o = q.ps_s[1];
        end
      end
      PSB_WDATA: begin
        // shifted clock plays no part here
        if (ck_edge) begin
          d.addr = q.addr + AW'(1);
        end
      end
      default: d.ph = PSB_IDLE;
    endcase
    // select low watchdog, flags host overrun; placed after the phase case so a set beats the start clear
    if (cs_lo) begin
      if (q.low_n != 13'(SEL_LIMIT)) begin
        d.low_n = q.low_n + 13'h0001;
      end else begin
        d.over = 1'b1;
      end
    end else begin
      d.low_n = 13'h0000;
    end
    // select rising ends and releases bus
    if (sel_end) begin
      d.ph = PSB_IDLE;
      d.pins.dq_oe = 1'b0;
      d.pins.strobe_oe = 1'b0;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q <= '0;
      q.cs_s <= 2'b11;
      q.ph <= PSB_IDLE;
      q.extra <= `PSB_EXTRA_LAT_RST;
    end else begin
      q <= d;
    end
  end

  always_comb begin
    dq_o = q.pins.dq_o;
    dq_oe = q.pins.dq_oe;
    read_write_strobe_o = q.pins.strobe_o;
    read_write_strobe_oe = q.pins.strobe_oe;
    select_overrun = q.over;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // frame start as seen after the select synchroniser
  sequence s_frame_start;
    sel_start;
  endsequence

  // centered strobe edge seen during a read data phase
  sequence s_centered_edge;
    centered_read_strobe_option && q.ph == PSB_RDATA && ps_edge;
  endsequence

  a_reset_float: assert property (@(posedge mclk)
    !rst_n |=> !dq_oe && !read_write_strobe_oe)
    else $error("bus driven after reset");
  a_release_end: assert property (@(posedge mclk) disable iff (!rst_n)
    sel_end |=> !dq_oe && !read_write_strobe_oe)
    else $error("bus not released");
  a_start_ind: assert property (@(posedge mclk) disable iff (!rst_n)
    s_frame_start |=> read_write_strobe_oe)
    else $error("latency indicator missing");
  a_ind_value: assert property (@(posedge mclk) disable iff (!rst_n)
    s_frame_start |=> read_write_strobe_o == $past(q.extra))
    else $error("latency indicator wrong");
  a_write_float: assert property (@(posedge mclk) disable iff (!rst_n)
    q.ph == PSB_WDATA |-> !dq_oe)
    else $error("driving during write");
  a_read_drive: assert property (@(posedge mclk) disable iff (!rst_n)
    q.ph == PSB_RDATA |-> dq_oe && read_write_strobe_oe)
    else $error("read data not driven");
  a_centered_edge: assert property (@(posedge mclk) disable iff (!rst_n)
    s_centered_edge |=> read_write_strobe_o == $past(q.ps_s[1]))
    else $error("strobe not following shifted clock");
  a_over_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    s_frame_start |=> !select_overrun)
    else $error("overrun flag not cleared at start");
endmodule

// file: sim/psb_host.sv
`timescale 1ns/100ps
// ----------------------------------------
// host bus master model
// ----------------------------------------
module psb_host #(
  parameter int LAT = 4
) (
  input wire logic mclk,
  output logic select_n,
  output logic bus_clock,
  output logic shifted_clock,
  output logic [7:0] dq_i,
  output logic stb_i,
  input wire logic [7:0] dq_o,
  input wire logic stb_o
);
  logic [7:0] buf_q [8]; // write data in, read data out
  logic [7:0] msk; // write byte mask
  logic [7:0] sok; // strobe level matched per read byte
  initial begin
    select_n = 1'b1;
    bus_clock = 1'b0; // idle low before a frame
    shifted_clock = 1'b0;
    dq_i = 8'h00;
    stb_i = 1'b0;
  end
  // one bus clock half period of eleven cycles, one byte per edge
  task automatic half(input logic sh, input logic [7:0] d, input logic m);
    dq_i <= d;
    stb_i <= m;
    @(negedge mclk);
    bus_clock <= ~bus_clock;
    repeat (5) @(negedge mclk);
    if (sh) shifted_clock <= ~shifted_clock; // quarter period late
    repeat (5) @(negedge mclk);
  endtask
  // whole framed transfer
  task automatic xfer(input logic rd, input logic [7:0] a, input int n, input int hold, output logic ind);
    logic [7:0] ca [6];
    int lat;
    ca = '{{rd, 7'h00}, 8'h00, 8'h00, 8'h00, 8'h00, a};
    select_n <= 1'b0;
    repeat (6) @(negedge mclk);
    ind = stb_o;
    lat = ind ? 4 * LAT : 2 * LAT;
    for (int i = 0; i < 6; i++) half(rd, ca[i], 1'b0);
    for (int i = 0; i < lat; i++) half(rd, 8'($urandom), 1'b0);
    for (int i = 0; i < n; i++) begin
      half(rd, rd ? 8'($urandom) : buf_q[i], rd ? 1'($urandom) : msk[i]);
      if (rd) begin
        buf_q[i] = dq_o;
        sok[i] = (stb_o === bus_clock);
      end
    end
    repeat (hold) @(negedge mclk);
    select_n <= 1'b1; // short frames keep the low limit
    dq_i <= ~dq_i;
    repeat (8) @(negedge mclk);
  endtask
endmodule

// file: sim/tb.sv
`timescale 1ns/100ps
module tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic opt = 1'b0;
  logic select_n, bus_clock, shifted_clock, stb_i, stb_o, stb_oe, dq_oe, ovr, exp_ind;
  logic [7:0] dq_i, dq_o, a;
  logic [7:0] mem [256]; // expected array contents
  int n, error_cnt, check_count;
  always #4 mclk = ~mclk;
  psb_dev #(.AW(8), .LAT(4), .SEL_LIMIT(600)) dut (.mclk(mclk), .rst_n(rst_n), .select_n(select_n),
    .bus_clock(bus_clock), .shifted_clock(shifted_clock), .centered_read_strobe_option(opt),
    .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .read_write_strobe_i(stb_i), .read_write_strobe_o(stb_o),
    .read_write_strobe_oe(stb_oe), .select_overrun(ovr));
  psb_host #(.LAT(4)) host (.mclk(mclk), .select_n(select_n), .bus_clock(bus_clock),
    .shifted_clock(shifted_clock), .dq_i(dq_i), .stb_i(stb_i), .dq_o(dq_o), .stb_o(stb_o));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (error_cnt == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // one transfer plus indicator and release checks
  task automatic run(input logic rd, input logic [7:0] ad, input int len, input int hold);
    logic ind;
    host.xfer(rd, ad, len, hold, ind);
    check(ind, exp_ind);
    exp_ind = ~exp_ind;
    check({dq_oe, stb_oe}, 8'h00);
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    stop_test;
  end
  initial begin
    void'($urandom(32'ha5da));
    exp_ind = 1'b1;
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    host.msk = 8'h00;
    // fill the whole array
    for (int b = 0; b < 32; b++) begin
      for (int i = 0; i < 8; i++) begin
        mem[b * 8 + i] = 8'($urandom);
        host.buf_q[i] = mem[b * 8 + i];
      end
      run(1'b0, 8'(b * 8), 8, 0);
    end
    // masked writes read back, first one unmasked from fc, wrapping only when longer than four bytes
    for (int k = 0; k < 12; k++) begin
      a = (k == 0) ? 8'hfc : 8'($urandom);
      n = 2 * $urandom_range(4, 1);
      opt = k[0];
      host.msk = (k == 0) ? 8'h00 : 8'($urandom);
      for (int i = 0; i < 8; i++) host.buf_q[i] = 8'($urandom);
      for (int i = 0; i < n; i++) if (!host.msk[i]) mem[8'(a + i)] = host.buf_q[i];
      run(1'b0, a, n, 0);
      run(1'b1, a, n, 0);
      for (int i = 0; i < n; i++) begin
        check(host.buf_q[i], mem[8'(a + i)]);
        check(8'(host.sok[i]), 8'h01);
      end
    end
    // select held too long, then cleared, then reset
    host.msk = 8'hff;
    run(1'b0, 8'h00, 2, 700);
    check(8'(ovr), 8'h01);
    run(1'b1, 8'h00, 2, 0);
    check(8'(ovr), 8'h00);
    run(1'b0, 8'h00, 2, 700);
    rst_n = 1'b0;
    repeat (3) @(negedge mclk);
    check({dq_oe, stb_oe, ovr}, 8'h00);
    rst_n = 1'b1;
    exp_ind = 1'b1;
    repeat (3) @(negedge mclk);
    run(1'b1, 8'h10, 2, 0);
    check(host.buf_q[0], mem[8'h10]);
    stop_test;
  end
endmodule
